// ===== bench/ows_panel_model.sv
// Purpose: Front-panel pause key and trigger line facing the sequencer
// Assumes: Same clock as the bench; both lines idle low between presses
// Notes: Counts trigger pulses from the block and flags any that last too long
`default_nettype none
module ows_panel_model
(
    // Clock
    input wire logic clk,
    // Trigger line and panel key
    input wire logic trig_out,
    output var logic trig_in,
    output var logic pause_req
);
    timeunit 1ns;
    timeprecision 1ps;
    int pulses = 0; // Trigger pulses seen
    int wide = 0; // Extra high cycles of pulses longer than one cycle
    logic last_q = 1'b0; // Trigger level one cycle ago
    // Lines start released
    initial
    begin
        trig_in = 1'b0;
        pause_req = 1'b0;
    end
    always @(posedge clk)
    begin
        if (trig_out === 1'b1 && last_q !== 1'b1)
            pulses++;
        if (trig_out === 1'b1 && last_q === 1'b1)
            wide++;
        last_q <= trig_out;
    end
    task automatic press(input bit trig);
        @(posedge clk);
        if (trig)
            trig_in <= 1'b1;
        else
            pause_req <= 1'b1;
        repeat (4) @(posedge clk);
        trig_in <= 1'b0;
        pause_req <= 1'b0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== bench/ows_sequencer_tb.sv
// Purpose: Self-checking bench for the output waveform sequencer
// Assumes: Memories are loaded over the register bus before any run
// Notes: Setpoint changes are logged with cycle stamps and judged per run
`default_nettype none
module ows_sequencer_tb
    import ows_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic trig_in, pause_req, trig_out, output_on, running;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd_q;
    logic [15:0] volt_setpoint, curr_setpoint, lv = 16'h0, lc = 16'h0;
    logic [15:0] vq[$], cq[$], oq[$]; // Logged changes and on flags
    int tq[$]; // Cycle stamp of each change
    int cyc = 0, age = 0, errors = 0, checks_done = 0;
    // Step words {ramp,trig,on,pause,value} and durations
    localparam logic [31:0] SA[16] = '{32'h0002_1111, 32'h0002_2222, 32'h0004_3333,
        32'h0002_4444, 32'h0002_5555, 32'h0002_6666, 32'h0002_7777, 32'h0002_8888,
        32'h0002_9999, 32'h0003_A0A0, 32'h0002_B0B0, 32'h0002_C0C0, 32'h0009_0123,
        32'h0009_0456, 32'h000A_0888, 32'h0000_0000};
    localparam int SD[16] = '{2, 0, 1, 1, 1, 1, 1, 1, 1, 1, 3, 1, 0, 0, 2, 0};
    localparam int PGS[7] = '{0, 4, 5, 7, 9, 12, 14};
    localparam int PGL[7] = '{4, 1, 2, 2, 3, 2, 1};
    ows_sequencer dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
        .pause_req(pause_req), .trig_out(trig_out), .volt_setpoint(volt_setpoint),
        .curr_setpoint(curr_setpoint), .output_on(output_on), .running(running));
    ows_panel_model pm_u (.clk(clk), .trig_out(trig_out), .trig_in(trig_in),
        .pause_req(pause_req));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Log setpoint changes; sample the on flag once a step has settled
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        age <= age + 1;
        if (age == 3)
            oq.push_back({15'h0, output_on});
        if (volt_setpoint !== lv)
        begin
            vq.push_back(volt_setpoint);
            tq.push_back(cyc);
            age <= 0;
        end
        if (curr_setpoint !== lc)
        begin
            cq.push_back(curr_setpoint);
            tq.push_back(cyc);
        end
        lv <= volt_setpoint;
        lc <= curr_setpoint;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic chkq(input logic [15:0] q[$], input logic [15:0] e[$]);
        chk(q.size(), e.size());
        foreach (e[i])
            if (i < q.size())
                chk({16'h0, q[i]}, {16'h0, e[i]});
    endtask
    // One Avalon-MM transfer, held until waitrequest is sampled low
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= ~we;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd_q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(32'(n < 50), 32'h1);
    endtask
    task automatic sq(input logic [2:0] s, input logic [31:0] a);
        bus(1'b1, REG_SEQ_SEL, {29'h0, s});
        bus(1'b1, REG_SEQ_A, a);
        bus(1'b1, REG_SEQ_B, 32'h1);
    endtask
    function automatic logic [31:0] sa(logic ce, logic [2:0] c, logic ee, logic [3:0] e,
        logic [13:0] l, logic [3:0] p);
        return {ce, c, 5'h0, ee, e, l, p};
    endfunction
    // Start a sequence and wait until it is seen running
    task automatic go(input logic [2:0] s, input logic [31:0] md);
        int n;
        vq.delete();
        cq.delete();
        oq.delete();
        tq.delete();
        bus(1'b1, REG_CTRL, {21'h0, s, 8'h0} | md | (32'h1 << CTRL_RUN));
        n = 0;
        while (running !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 50), 32'h1);
    endtask
    task automatic fin(input int lim);
        int n;
        n = 0;
        while (running !== 1'b0 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        // Let the last setpoint change reach the log
        repeat (3) @(posedge clk);
        chk(32'(n < lim), 32'h1);
    endtask
    task automatic load();
        for (int i = 0; i < 16; i++)
        begin
            bus(1'b1, REG_STEP_SEL, 32'(i));
            bus(1'b1, REG_STEP_A, SA[i]);
            bus(1'b1, REG_STEP_B, 32'(SD[i]));
        end
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b1, REG_PROG_SEL, 32'(i));
            bus(1'b1, REG_PROG, 32'((PGL[i] << 10) | PGS[i]));
        end
        sq(3'h0, sa(1'b0, 3'h0, 1'b0, 4'h0, 14'h0002, 4'h0));
        sq(3'h1, sa(1'b1, 3'h2, 1'b1, 4'h3, 14'h0001, 4'h1));
        sq(3'h2, sa(1'b0, 3'h0, 1'b1, 4'h3, 14'h0001, 4'h2));
        sq(3'h3, sa(1'b0, 3'h0, 1'b0, 4'h0, 14'h0001, 4'h6));
        sq(3'h4, sa(1'b0, 3'h0, 1'b0, 4'h0, 14'h0001, 4'h4));
        sq(3'h5, sa(1'b0, 3'h0, 1'b0, 4'h0, LOOP_FOREVER, 4'h2));
        sq(3'h6, sa(1'b0, 3'h0, 1'b0, 4'h0, 14'h0001, 4'h5));
    endtask
    // Lone program, two loops, skipped step, trigger and on flags
    task automatic t_lone();
        int p0;
        p0 = pm_u.pulses;
        go(3'h0, 32'h0);
        fin(4000);
        chkq(vq, '{16'h1111, 16'h3333, 16'h4444, 16'h1111, 16'h3333, 16'h4444});
        chkq(oq, '{16'h1, 16'h0, 16'h1, 16'h1, 16'h0, 16'h1});
        chk(pm_u.pulses - p0, 2);
        chk(pm_u.wide, 0);
        chk(cq.size(), 0);
        chk(32'(tq[1] - tq[0] inside {[2 * TICK_CYC:2 * TICK_CYC + 10]}), 1);
    endtask
    // Chain skips the end program; end program plays its first step only
    task automatic t_chain();
        go(3'h1, 32'h0);
        fin(3000);
        chkq(vq, '{16'h5555, 16'h6666, 16'h7777, 16'h8888});
    endtask
    // Two-tick ramp from 8888 to 0888: halfway value after one tick
    task automatic t_ramp();
        go(3'h3, 32'h0);
        fin(1000);
        chkq(vq, '{16'h4888, 16'h0888});
        chk(oq[0], 16'h1);
        chk(vq[vq.size() - 1], 16'h0888);
    endtask
    // Pause-flag step halts; trigger resumes; key pauses and resumes
    task automatic t_pause();
        go(3'h4, 32'h0);
        repeat (600) @(posedge clk);
        chk(vq.size(), 1);
        pm_u.press(1'b1);
        repeat (250) @(posedge clk);
        chk(vq[vq.size() - 1], 16'hB0B0);
        pm_u.press(1'b0);
        repeat (1000) @(posedge clk);
        chk(vq.size(), 2);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd_q[2], 1'b1);
        pm_u.press(1'b0);
        fin(2000);
        chkq(vq, '{16'hA0A0, 16'hB0B0, 16'hC0C0});
    endtask
    task automatic t_endless();
        go(3'h5, 32'h0);
        repeat (4000) @(posedge clk);
        chk(running, 1'b1);
        chk(32'(vq.size() >= 16), 1);
        bus(1'b1, REG_CTRL, 32'h1 << CTRL_STOP);
        fin(600);
    endtask
    // Fast current run: fixed duration, pause and ramp ignored
    task automatic t_fast();
        go(3'h6, (32'h1 << CTRL_FAST) | (32'h1 << CTRL_CURR));
        repeat (100) @(posedge clk);
        pm_u.press(1'b0);
        fin(1000);
        chkq(cq, '{16'h0123, 16'h0456});
        chk(vq.size(), 0);
        chk(32'(tq[1] - tq[0] inside {[TICK_CYC:TICK_CYC + 10]}), 1);
        bus(1'b0, 8'hFC, 32'h0);
        chk(rd_q, RD_UNMAPPED);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #300000;
        errors++;
        conclude();
    end
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        load();
        t_lone();
        t_chain();
        t_ramp();
        t_pause();
        t_endless();
        t_fast();
        conclude();
    end
endmodule
`default_nettype wire

// ===== core/ows_pkg.sv
// Purpose: Shared constants and types for the output waveform sequencer
// Assumes: One 200 MHz clock, synchronous active-low reset
// Notes: Offsets are word byte addresses on the Avalon-MM register port
`default_nettype none
package ows_pkg;
    // Capacities
    localparam int NORM_STEPS = 256;
    localparam int FAST_STEPS = 1024;
    localparam int NUM_PROGS = 16;
    localparam int NUM_SEQS = 8;
    localparam logic [13:0] LOOP_FOREVER = 14'h270F;
    // Time base: one duration tick is 1 us
    localparam int CLK_MHZ = 200;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SEQ_SEL = 8'h08;
    localparam logic [7:0] REG_SEQ_A = 8'h0C;
    localparam logic [7:0] REG_SEQ_B = 8'h10;
    localparam logic [7:0] REG_PROG_SEL = 8'h14;
    localparam logic [7:0] REG_PROG = 8'h18;
    localparam logic [7:0] REG_STEP_SEL = 8'h1C;
    localparam logic [7:0] REG_STEP_A = 8'h20;
    localparam logic [7:0] REG_STEP_B = 8'h24;
    localparam logic [7:0] REG_SETPT = 8'h28;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // Control bit positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_PAUSE = 2;
    localparam int CTRL_FAST = 3;
    localparam int CTRL_CURR = 4;
    localparam int CTRL_SEQ_LSB = 8;
    // Sequencer states
    typedef enum logic [2:0] {
        OWS_IDLE, OWS_LOAD, OWS_FETCH, OWS_RUN, OWS_NEXT, OWS_END
    } ows_state_e;
endpackage
`default_nettype wire

// ===== core/ows_sequencer.sv
// Purpose: Plays stored setpoint programs chained by sequence descriptors
// Assumes: Avalon-MM slave with waitrequest; trigger input synchronous-ish
// Notes: Step memory is shared by both speed modes; program table gives start and length
//
// What this block does
// [RULE1] Steps run ascending from program's first step
// [RULE2] Normal mode: 256 steps over 16 programs
// [RULE3] Fast mode: 1024 steps, value plus trigger
// [RULE4] Eight descriptors: program, loops, end, chain
// [RULE5] Repeat program by descriptor loop count
// [RULE6] End program: first step only, then stop
// [RULE7] Chain field selects next sequence descriptor
// [RULE8] Normal step: ramp, value, trig, on, pause, time
// [RULE9] Fast mode: one duration from descriptor
// [RULE10] Step jumps; ramp interpolates, normal mode only
// [RULE11] Trigger flag gives one pulse at change
// [RULE12] Pause toggles; trigger resumes; fast ignores pause
// [RULE13] Pause-flag step halts until trigger or pause
// [RULE14] Output enable follows normal step on flag
// [RULE15] One step format; lone program runnable
// [RULE16] Voltage modes drive voltage, current modes current
// [RULE17] Loops 1..9998 literal, 9999 endless
// [RULE18] Zero-duration normal step skipped, no change
// [RULE19] Chain given: skip end program, go chain
// [RULE20] Trigger out one cycle; input synchronised
`default_nettype none
module ows_sequencer
    import ows_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Trigger line and panel pause
    input wire logic trig_in,
    input wire logic pause_req,
    output logic trig_out,
    // Output setpoints
    output logic [15:0] volt_setpoint,
    output logic [15:0] curr_setpoint,
    output logic output_on,
    output logic running
);
    import ows_pkg::*;

    // Memories: steps {ramp,trig,on,pause,value[15:0]} and durations
    logic [19:0] step_mem [FAST_STEPS];
    logic [23:0] dur_mem [NORM_STEPS];
    logic [19:0] prog_mem [NUM_PROGS];   // {len[9:0], start[9:0]}
    logic [31:0] seqa_mem [NUM_SEQS];    // {chain_en,chain[2:0],end_en,end[3:0],loops[13:0],prog}
    logic [23:0] seqb_mem [NUM_SEQS];    // Fast step duration

    // Control registers
    logic [31:0] ctrl_q;
    logic [2:0] seq_sel_q;
    logic [3:0] prog_sel_q;
    logic [9:0] step_sel_q;
    logic ack_q;

    // Sequencer state
    ows_state_e st_q;
    logic [2:0] seq_q;
    logic [9:0] ptr_q, last_q;
    logic [13:0] loops_q, lcnt_q;
    logic [23:0] dur_q;
    logic [7:0] tick_q;
    logic paused_q, ending_q;
    logic [15:0] sp_q, from_q, to_q;
    logic ramp_q;

    // Bus decode
    wire bus_req = (avs_read | avs_write) & ~ack_q;
    // Writes land in the answer cycle, while waitrequest is low
    wire wr = avs_write & ack_q;
    wire wr_ctrl = wr && avs_address == REG_CTRL;
    wire fast = ctrl_q[CTRL_FAST];
    wire [31:0] seq_a = seqa_mem[seq_q];
    wire [19:0] pent = prog_mem[seq_a[3:0]];
    wire [19:0] eent = prog_mem[seq_a[21:18]];
    wire [19:0] sword = step_mem[ptr_q];
    wire [23:0] sdur = fast ? seqb_mem[seq_q] : dur_mem[ptr_q[7:0]];

    // Trigger input synchroniser and edge
    logic trs1_q, trs2_q, trs3_q, pz_q;
    // [RULE20] sync and edge
    wire trig_rise = trs2_q & ~trs3_q;
    wire pause_rise = (pause_req & ~pz_q) | (wr_ctrl & avs_writedata[CTRL_PAUSE]);
    // [RULE12] fast mode ignores pausing
    wire resume = trig_rise | pause_rise;
    wire tick = tick_q == 8'(TICK_CYC - 1);
    wire dur_done = tick && dur_q <= 24'h000001;

    // Read mux
    logic [31:0] rd_d;
    always_comb
    begin
        // Unmapped addresses read zero
        if (avs_address == REG_CTRL) rd_d = ctrl_q;
        else if (avs_address == REG_STATUS)
            rd_d = {21'h000000, seq_q, 5'h0, paused_q, running, 1'b0};
        else if (avs_address == REG_SEQ_SEL) rd_d = {29'h0, seq_sel_q};
        else if (avs_address == REG_SEQ_A) rd_d = seqa_mem[seq_sel_q];
        else if (avs_address == REG_SEQ_B) rd_d = {8'h00, seqb_mem[seq_sel_q]};
        else if (avs_address == REG_PROG_SEL) rd_d = {28'h0, prog_sel_q};
        else if (avs_address == REG_PROG) rd_d = {12'h000, prog_mem[prog_sel_q]};
        else if (avs_address == REG_STEP_SEL) rd_d = {22'h0, step_sel_q};
        else if (avs_address == REG_STEP_A) rd_d = {12'h000, step_mem[step_sel_q]};
        else if (avs_address == REG_STEP_B) rd_d = {8'h00, dur_mem[step_sel_q[7:0]]};
        else if (avs_address == REG_SETPT) rd_d = {16'h0000, sp_q};
        else rd_d = RD_UNMAPPED;
    end

    // Bus handshake: answer one cycle after request
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= bus_req;
            // Wait drops only in the answer cycle
            avs_waitrequest <= ~bus_req;
            avs_readdata <= rd_d;
        end
    end

    // Control and select register writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q <= 32'h0000_0000;
            seq_sel_q <= 3'h0;
            prog_sel_q <= 4'h0;
            step_sel_q <= 10'h000;
        end
        else
        begin
            // Run, stop and pause bits self-clear
            ctrl_q[2:0] <= 3'h0;
            if (wr_ctrl) ctrl_q <= avs_writedata;
            if (wr && avs_address == REG_SEQ_SEL) seq_sel_q <= avs_writedata[2:0];
            if (wr && avs_address == REG_PROG_SEL) prog_sel_q <= avs_writedata[3:0];
            if (wr && avs_address == REG_STEP_SEL) step_sel_q <= avs_writedata[9:0];
        end
    end

    // Table writes; no reset on memories
    always_ff @(posedge clk)
    begin
        // [RULE4] descriptor store
        if (wr && avs_address == REG_SEQ_A) seqa_mem[seq_sel_q] <= avs_writedata;
        // [RULE9] fast duration per descriptor
        if (wr && avs_address == REG_SEQ_B) seqb_mem[seq_sel_q] <= avs_writedata[23:0];
        if (wr && avs_address == REG_PROG) prog_mem[prog_sel_q] <= avs_writedata[19:0];
        // [RULE15] one step format for all programs
        if (wr && avs_address == REG_STEP_A) step_mem[step_sel_q] <= avs_writedata[19:0];
        // [RULE2] normal durations cover 256 steps
        if (wr && avs_address == REG_STEP_B) dur_mem[step_sel_q[7:0]] <= avs_writedata[23:0];
    end

    // Input sampling
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            trs1_q <= 1'b0;
            trs2_q <= 1'b0;
            trs3_q <= 1'b0;
            pz_q <= 1'b0;
        end
        else
        begin
            trs1_q <= trig_in;
            trs2_q <= trs1_q;
            trs3_q <= trs2_q;
            pz_q <= pause_req;
        end
    end

    // Ramp interpolation: from + (to-from)*(elapsed/total)
    logic [23:0] step_mem_dur_total;
    wire [23:0] elapsed = (step_mem_dur_total - dur_q);
    wire signed [17:0] span = $signed({2'b00, to_q}) - $signed({2'b00, from_q});
    wire signed [42:0] prod = span * $signed({1'b0, elapsed});
    wire signed [42:0] quot = step_mem_dur_total == 24'h0 ? 43'sh0
                              : prod / $signed({19'h0, step_mem_dur_total});
    wire [15:0] ramp_sp = 16'(from_q + quot[15:0]);

    // Main sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= OWS_IDLE;
            seq_q <= 3'h0;
            ptr_q <= 10'h000;
            last_q <= 10'h000;
            loops_q <= 14'h0000;
            lcnt_q <= 14'h0000;
            dur_q <= 24'h000000;
            step_mem_dur_total <= 24'h000000;
            tick_q <= 8'h00;
            paused_q <= 1'b0;
            ending_q <= 1'b0;
            sp_q <= 16'h0000;
            from_q <= 16'h0000;
            to_q <= 16'h0000;
            ramp_q <= 1'b0;
            trig_out <= 1'b0;
            output_on <= 1'b0;
            running <= 1'b0;
        end
        else
        begin
            trig_out <= 1'b0;
            tick_q <= tick ? 8'h00 : tick_q + 8'h01;
            case (st_q)
                OWS_IDLE:
                begin
                    running <= 1'b0;
                    paused_q <= 1'b0;
                    if (wr_ctrl && avs_writedata[CTRL_RUN])
                    begin
                        seq_q <= avs_writedata[CTRL_SEQ_LSB +: 3];
                        // Start from the present output of the sequenced quantity
                        sp_q <= avs_writedata[CTRL_CURR] ? curr_setpoint : volt_setpoint;
                        st_q <= OWS_LOAD;
                    end
                end
                OWS_LOAD:
                begin
                    // [RULE1] begin at the program's first step
                    running <= 1'b1;
                    ending_q <= 1'b0;
                    ptr_q <= pent[9:0];
                    last_q <= 10'(pent[9:0] + pent[19:10] - 10'h001);
                    loops_q <= seq_a[17:4];
                    lcnt_q <= 14'h0001;
                    st_q <= pent[19:10] == 10'h000 ? OWS_NEXT : OWS_FETCH;
                end
                OWS_FETCH:
                begin
                    // [RULE18] zero duration normal step skipped
                    if (!fast && !ending_q && sdur == 24'h0) st_q <= OWS_NEXT;
                    else
                    begin
                        // [RULE11] pulse at step change
                        trig_out <= sword[18];
                        // [RULE3] fast step: value and trigger only
                        // [RULE10] ramp only when normal
                        ramp_q <= sword[19] & ~fast & ~ending_q;
                        from_q <= sp_q;
                        to_q <= sword[15:0];
                        if (!(sword[19] & ~fast & ~ending_q)) sp_q <= sword[15:0];
                        // [RULE14] enable per step; fast stays on
                        output_on <= fast | sword[17];
                        // [RULE8] [RULE13] pause flag halts step
                        paused_q <= ~fast & ~ending_q & sword[16];
                        dur_q <= sdur;
                        step_mem_dur_total <= sdur;
                        // Restart the tick so a step lasts whole ticks
                        tick_q <= 8'h00;
                        // [RULE6] end program: stop after first step
                        st_q <= ending_q ? OWS_IDLE : OWS_RUN;
                    end
                end
                OWS_RUN:
                begin
                    if (ramp_q) sp_q <= ramp_sp;
                    // [RULE12] pause halts; second pause or trigger resumes
                    if (!fast && resume) paused_q <= ~paused_q & ~trig_rise;
                    else if (!paused_q && tick)
                    begin
                        dur_q <= dur_q - 24'h000001;
                        if (dur_done)
                        begin
                            if (ramp_q) sp_q <= to_q;
                            st_q <= OWS_NEXT;
                        end
                    end
                end
                OWS_NEXT:
                begin
                    if (ptr_q != last_q && pent[19:10] != 10'h000)
                    begin
                        ptr_q <= ptr_q + 10'h001;
                        st_q <= OWS_FETCH;
                    end
                    // [RULE5] [RULE17] repeat; 9999 endless
                    else if (loops_q == LOOP_FOREVER || lcnt_q < loops_q)
                    begin
                        lcnt_q <= lcnt_q + 14'h0001;
                        ptr_q <= pent[9:0];
                        st_q <= pent[19:10] == 10'h000 ? OWS_END : OWS_FETCH;
                    end
                    else st_q <= OWS_END;
                end
                OWS_END:
                begin
                    // [RULE7] [RULE19] chain beats end program
                    if (seq_a[31])
                    begin
                        seq_q <= seq_a[30:28];
                        st_q <= OWS_LOAD;
                    end
                    else if (seq_a[22])
                    begin
                        ending_q <= 1'b1;
                        ptr_q <= eent[9:0];
                        st_q <= OWS_FETCH;
                    end
                    else st_q <= OWS_IDLE;
                end
                default: st_q <= OWS_IDLE;
            endcase
            // Stop request returns to idle
            if (st_q != OWS_IDLE && ctrl_q[CTRL_STOP]) st_q <= OWS_IDLE;
        end
    end

    // [RULE16] voltage or current setpoint only
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            volt_setpoint <= 16'h0000;
            curr_setpoint <= 16'h0000;
        end
        else if (ctrl_q[CTRL_CURR]) curr_setpoint <= sp_q;
        else volt_setpoint <= sp_q;
    end

    // [RULE20] trigger pulse is one cycle
    a_trig_pulse: assert property (@(posedge clk) disable iff (!rst_n) // [RULE20]
        trig_out |=> !trig_out)
        else $error("trigger pulse longer than one cycle");
    // [RULE11] pulse only on fetch
    a_trig_cause: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        trig_out |-> $past(st_q) == OWS_FETCH && $past(sword[18]))
        else $error("trigger pulse without flagged step");
    // [RULE12] no pause in fast mode
    a_fast_nopause: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        fast && $past(fast) && st_q == OWS_RUN |-> !paused_q || $past(paused_q))
        else $error("pause entered in fast mode");
    // [RULE14] fast mode keeps output on
    a_fast_on: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
        $past(st_q) == OWS_FETCH && st_q == OWS_RUN && fast |-> output_on)
        else $error("fast step output off");
    // [RULE10] plain step jumps at once
    a_step_jump: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        st_q == OWS_RUN && $past(st_q) == OWS_FETCH && !ramp_q |-> sp_q == to_q)
        else $error("step setpoint not applied");
    // [RULE19] chain leads to load
    a_chain_load: assert property (@(posedge clk) disable iff (!rst_n) // [RULE19]
        st_q == OWS_END && seq_a[31] && !ctrl_q[CTRL_STOP] |=> st_q == OWS_LOAD)
        else $error("chain not followed");
    // [RULE6] end step then idle
    a_end_stop: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        st_q == OWS_FETCH && ending_q |=> st_q == OWS_IDLE)
        else $error("end program ran past first step");
    // [RULE1] load starts at first step
    a_load_first: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        st_q == OWS_LOAD |=> ptr_q == $past(pent[9:0]))
        else $error("program not started at first step");
endmodule
`default_nettype wire
